// ===== verilog/ccp_pkg.sv
`default_nettype none
package ccp_pkg;
  // core clock and timing figures
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned QUIET_MS   = 1500;  // link-drop wait before pulses
  localparam int unsigned FAIL_MS    = 125;   // continuous signal means fail
  localparam int unsigned SLOT_MS    = 62;    // crossover sampling slot
  localparam int unsigned QUIET_CYC  = QUIET_MS * CYC_PER_MS;
  localparam int unsigned FAIL_CYC   = FAIL_MS * CYC_PER_MS;
  localparam int unsigned SLOT_CYC   = SLOT_MS * CYC_PER_MS;

  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_CTRL   = 5'h10;
  localparam logic [4:0] IDX_STAT   = 5'h11;
  localparam logic [4:0] IDX_SEL    = 5'h16;
  localparam logic [4:0] IDX_CABLE  = 5'h1c;
  // selector values that open the two extra pages of the cable register
  localparam logic [7:0] PAGE_SKEW  = 8'h04;
  localparam logic [7:0] PAGE_POL   = 8'h05;
  localparam logic [7:0] PAIR_LAST  = 8'h03;
  // field positions
  localparam int CTRL_XMODE = 5;   // 6:5 crossover mode
  localparam int STAT_LEN   = 7;   // 9:7 dsp cable length
  localparam int STAT_MDIX  = 6;
  localparam int STAT_POL   = 1;
  localparam int CAB_START  = 15;
  localparam int CAB_VERD   = 13;  // 14:13
  localparam int CAB_AMP    = 8;   // 12:8
  localparam int PG5_MAP    = 4;   // 5:4
  localparam int PG5_VALID  = 6;
  localparam logic [10:0] LFSR_SEED = 11'h0_5a5;

  typedef enum logic [1:0] {
    V_NORMAL = 2'b00, V_SHORT = 2'b01, V_OPEN = 2'b10, V_FAIL = 2'b11
  } ccp_verdict_t;
  typedef enum logic [1:0] {
    X_MDI = 2'b00, X_MDIX = 2'b01, X_RSVD = 2'b10, X_AUTO = 2'b11
  } ccp_xmode_t;
  typedef enum logic [1:0] {
    SP_10 = 2'b00, SP_100 = 2'b01, SP_1000 = 2'b10, SP_NONE = 2'b11
  } ccp_speed_t;
  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_QUIET = 3'b001, T_PULSE = 3'b010,
    T_LISTEN = 3'b011, T_DONE = 3'b100
  } ccp_tst_t;

  // reflection report from the analog front end
  typedef struct packed {
    logic       hit;   // a reflection came back
    logic       neg;   // reflection is negative
    logic [4:0] amp;
    logic [7:0] dly;
  } ccp_tdr_t;

  // line and dsp status
  typedef struct packed {
    ccp_speed_t  speed;
    logic        link_up;
    logic        descr_lock;
    logic        sig_det;
    logic        link_pulse;
    logic        pulse_inv;
    logic [3:0]  idle_inv;
    logic        cd_swap;
    logic [2:0]  len;
    logic [15:0] skew;
  } ccp_line_t;

  typedef struct packed {
    ccp_verdict_t verd;
    logic [4:0]   amp;
    logic [7:0]   dly;
  } ccp_res_t;

  typedef struct packed {
    logic           ack;
    logic [31:0]    rdata;
    ccp_xmode_t     xmode;
    logic [7:0]     sel;
    logic           start;
    ccp_tst_t       tst;
    logic [27:0]    cnt;
    logic [27:0]    sig_cnt;
    logic [1:0]     pair;
    ccp_res_t [3:0] res;
    logic           pulse;
    logic           mdix;
    logic [27:0]    slot;
    logic           act_seen;
    logic [10:0]    lfsr;
    logic [3:0]     pol;
    logic           an_en;
  } ccp_st_t;
endpackage
`default_nettype wire

// ===== verilog/ccp_cable_diag.sv
`timescale 1ns/1ps
`default_nettype none
module ccp_cable_diag
  import ccp_pkg::*;
#(
  parameter int unsigned QUIET_N = ccp_pkg::QUIET_CYC,
  parameter int unsigned FAIL_N  = ccp_pkg::FAIL_CYC,
  parameter int unsigned SLOT_N  = ccp_pkg::SLOT_CYC
)(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic                    wb_ack_o,
  output logic [31:0]             wb_dat_o,
  // strap
  input  wire logic               auto_crossover_strap_i,
  // line status and reflectometry front end
  input  wire ccp_pkg::ccp_line_t line_i,
  input  wire logic               tdr_done_i,
  input  wire ccp_pkg::ccp_tdr_t  tdr_i,
  output logic                    tdr_active_o,
  output logic                    tdr_pulse_o,
  output logic [1:0]              tdr_pair_o,
  // pair mapping and polarity
  output logic                    mdix_o,
  output logic [3:0]              pol_invert_o,
  output logic                    an_enable_o
);

  ////////////////////////////////////////////////////////////////////////////
  // terminal counts; 28 bits cover the longest wait at full clock rate
  localparam logic [27:0] QUIET_L = 28'(QUIET_N - 1);
  localparam logic [27:0] FAIL_L  = 28'(FAIL_N - 1);
  localparam logic [27:0] SLOT_L  = 28'(SLOT_N - 1);
  // sweep ends on this pair
  localparam logic [1:0]  LAST_PAIR = PAIR_LAST[1:0];

  // whole block state and its next value
  ccp_st_t s_r;
  ccp_st_t s_nxt;
  logic    req;
  logic    wr;
  logic [4:0] idx;
  logic    adr_ok;
  logic    gig_ok;
  logic    rx_pol;
  logic [31:0] rd;

  // bus decode: unmapped word lanes still acknowledge and read zero
  // ack is registered: a request is taken once, answered one cycle on
  assign req    = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign wr     = req & wb_we_i;
  assign idx    = wb_adr_i[6:2];
  assign adr_ok = ~wb_adr_i[7] & (wb_adr_i[1:0] == 2'b00);
  // page contents only meaningful on a locked gigabit link
  assign gig_ok = (line_i.speed == SP_1000) & line_i.link_up
                  & line_i.descr_lock;
  // receive pair is pair one when straight, pair zero when crossed
  assign rx_pol = s_r.mdix ? s_r.pol[0] : s_r.pol[1];

  ////////////////////////////////////////////////////////////////////////////
  // read data multiplexer
  // page four, and the cd_swap and valid bits of page five, read live line status, not a snapshot
  always_comb
  begin
    rd = 32'h0000_0000;
    if (adr_ok)
    begin
      case (idx)
        IDX_CTRL:
          rd[CTRL_XMODE +: 2] = s_r.xmode;
        IDX_STAT:
        begin
          if (line_i.link_up)
            rd[STAT_LEN +: 3] = line_i.len;
          rd[STAT_MDIX] = s_r.mdix;
          rd[STAT_POL] = rx_pol;
        end
        IDX_SEL:
          rd[7:0] = s_r.sel;
        IDX_CABLE:
        begin
          rd[CAB_START] = s_r.start;
          if (s_r.sel <= PAIR_LAST)
          begin
            rd[CAB_VERD +: 2] = s_r.res[s_r.sel[1:0]].verd;
            rd[CAB_AMP +: 5]  = s_r.res[s_r.sel[1:0]].amp;
            rd[7:0]           = s_r.res[s_r.sel[1:0]].dly;
          end
          else if (s_r.sel == PAGE_SKEW)
            rd[15:0] = line_i.skew;
          else if (s_r.sel == PAGE_POL)
          begin
            rd[3:0]         = s_r.pol;
            rd[PG5_MAP]     = s_r.mdix;
            rd[PG5_MAP + 1] = line_i.cd_swap;
            rd[PG5_VALID]   = gig_ok;
          end
        end
        default:
          rd = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  // later sections override earlier ones where they touch one field
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.ack   = req;
    s_nxt.pulse = 1'b0;
    if (req)
      s_nxt.rdata = rd;
    // free-running; the seed only keeps it off the all-zero lock-up
    s_nxt.lfsr = {s_r.lfsr[9:0], s_r.lfsr[10] ^ s_r.lfsr[8]};

    // register writes, low two byte lanes only
    // upper lanes hold no writable field, so they are simply ignored
    if (wr && adr_ok)
    begin
      case (idx)
        IDX_CTRL:
          if (wb_sel_i[0])
            s_nxt.xmode = ccp_xmode_t'(wb_dat_i[CTRL_XMODE +: 2]);
        IDX_SEL:
          if (wb_sel_i[0])
            s_nxt.sel = wb_dat_i[7:0];
        IDX_CABLE:
          if (wb_sel_i[1] && wb_dat_i[CAB_START] && s_r.tst == T_IDLE)
            s_nxt.start = 1'b1;
        default:
          s_nxt.sel = s_r.sel;
      endcase
    end

    // cable test sequencer
    case (s_r.tst)
      T_IDLE:
      begin
        s_nxt.cnt     = '0;
        s_nxt.sig_cnt = '0;
        if (s_r.start)
          s_nxt.tst = T_QUIET;
      end
      T_QUIET:
      begin
        // wait for partner to drop link
        if (s_r.cnt != QUIET_L)
          s_nxt.cnt = s_r.cnt + 28'h000_0001;
        // any gap restarts the count, so only an unbroken signal fails
        s_nxt.sig_cnt = line_i.sig_det ? s_r.sig_cnt + 28'h000_0001 : '0;
        if (line_i.sig_det && s_r.sig_cnt == FAIL_L)
        begin
          for (int p = 0; p < 4; p++)
          begin
            s_nxt.res[p].verd = V_FAIL;
            s_nxt.res[p].amp  = '0;
            s_nxt.res[p].dly  = '0;
          end
          s_nxt.tst = T_DONE;
        end
        else if (s_r.cnt == QUIET_L && !line_i.sig_det)
        begin
          s_nxt.pair = 2'b00;
          s_nxt.tst  = T_PULSE;
        end
      end
      T_PULSE:
      begin
        // request registered here, so the pulse shows in the listen state
        // one pulse per pair
        s_nxt.pulse = 1'b1;
        s_nxt.tst   = T_LISTEN;
      end
      T_LISTEN:
        // no timeout here: a front end that never answers stalls the test
        if (tdr_done_i)
        begin
          s_nxt.res[s_r.pair].amp = tdr_i.amp;
          s_nxt.res[s_r.pair].dly = tdr_i.dly;
          if (!tdr_i.hit)
            s_nxt.res[s_r.pair].verd = V_NORMAL;
          else if (tdr_i.neg)
            s_nxt.res[s_r.pair].verd = V_SHORT;
          else
            s_nxt.res[s_r.pair].verd = V_OPEN;
          if (s_r.pair == LAST_PAIR)
            s_nxt.tst = T_DONE;
          else
          begin
            s_nxt.pair = s_r.pair + 2'b01;
            s_nxt.tst  = T_PULSE;
          end
        end
      T_DONE:
      begin
        // one spare cycle: start falls only after all results have landed
        // start self-clears
        s_nxt.start = 1'b0;
        s_nxt.tst   = T_IDLE;
      end
      default:
        s_nxt.tst = T_IDLE;
    endcase

    // crossover resolution; frozen while linked or testing
    // a test restarts resolution from a clean slot when it ends
    if (s_r.tst != T_IDLE)
    begin
      s_nxt.an_en    = 1'b0;
      s_nxt.act_seen = 1'b0;
      s_nxt.slot     = '0;
    end
    else if (s_r.xmode == X_MDI || s_r.xmode == X_MDIX)
    begin
      // forced modes let negotiation run at once, nothing to resolve
      // forced setting
      s_nxt.mdix  = (s_r.xmode == X_MDIX);
      s_nxt.an_en = 1'b1;
    end
    else if (line_i.link_up)
      s_nxt.an_en = 1'b1;
    else
    begin
      if (line_i.link_pulse || line_i.sig_det)
        s_nxt.act_seen = 1'b1;
      s_nxt.an_en = s_r.an_en | s_r.act_seen;
      s_nxt.slot  = s_r.slot + 28'h000_0001;
      if (s_r.slot == SLOT_L)
      begin
        s_nxt.slot = '0;
        if (!s_r.act_seen && s_r.lfsr[0])
          s_nxt.mdix = ~s_r.mdix;
        // activity on the closing edge opens the next slot, so a steady
        // signal never loses it and negotiation is not restarted
        s_nxt.act_seen = line_i.link_pulse | line_i.sig_det;
        // negotiation follows the slot just ended; a silent slot stops it
        s_nxt.an_en    = s_r.act_seen;
      end
    end

    // receive polarity correction
    case (line_i.speed)
      SP_1000:
        if (!line_i.descr_lock)
          s_nxt.pol = line_i.idle_inv;
      SP_10:
        // track pulses until link is up
        if (!line_i.link_up && line_i.link_pulse)
        begin
          if (s_r.mdix)
            s_nxt.pol[0] = line_i.pulse_inv;
          else
            s_nxt.pol[1] = line_i.pulse_inv;
        end
      // polarity is meaningless at 100, so it reads as all clear
      // 100 needs no correction
      SP_100:
        s_nxt.pol = 4'h0;
      default:
        s_nxt.pol = s_r.pol;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; strap sampled while reset is held
  // strap is read on every reset edge, so it may settle late in reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r       <= '0;
      s_r.xmode <= auto_crossover_strap_i ? X_AUTO : X_MDI;
      s_r.mdix  <= 1'b0;
      s_r.tst   <= T_IDLE;
      s_r.lfsr  <= LFSR_SEED;
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from the state register; tdr_active_o is decoded from the test state
  // test pulse request lasts one cycle; pair holds until the echo
  assign wb_ack_o     = s_r.ack;
  assign wb_dat_o     = s_r.rdata;
  assign tdr_active_o = (s_r.tst != T_IDLE);
  assign tdr_pulse_o  = s_r.pulse;
  assign tdr_pair_o   = s_r.pair;
  // analog mux swaps a/b and tx/rx when high
  assign mdix_o       = s_r.mdix;
  assign pol_invert_o = s_r.pol;
  assign an_enable_o  = s_r.an_en;

endmodule
`default_nettype wire

// ===== sim/ccp_cable_diag_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ccp_cable_diag_checker
  import ccp_pkg::*;
#(
  parameter int unsigned QUIET_N = 200
)(
  // clock and reset
  input wire logic               clk_i,
  input wire logic               rst_i,
  // bus handshake
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  // line and test outputs
  input wire ccp_pkg::ccp_line_t line_i,
  input wire logic               tdr_active_o,
  input wire logic               tdr_pulse_o,
  input wire logic [1:0]         tdr_pair_o,
  input wire logic [3:0]         pol_invert_o,
  input wire logic               an_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] quiet_r;
  logic [1:0]  last_r;
  // time active so far, and pair of the latest pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !tdr_active_o)
      quiet_r <= 32'h0000_0000;
    else
      quiet_r <= quiet_r + 32'h0000_0001;
    if (rst_i)
      last_r <= 2'h3;
    else if (tdr_pulse_o)
      last_r <= tdr_pair_o;
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_glock;
    (line_i.speed == SP_1000 && line_i.descr_lock) [*3];
  endsequence
  sequence s_tlink;
    (line_i.speed == SP_10 && line_i.link_up) [*3];
  endsequence
  property p_ack;
    s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bad ack");
  property p_pls;
    tdr_pulse_o |-> tdr_active_o ##1 !tdr_pulse_o;
  endproperty
  a_pls: assert property (p_pls) else $error("bad pulse");
  property p_ord;
    tdr_pulse_o |-> tdr_pair_o == last_r + 2'h1;
  endproperty
  a_ord: assert property (p_ord) else $error("pair order");
  property p_qt;
    tdr_pulse_o |-> quiet_r >= QUIET_N - 1;
  endproperty
  a_qt: assert property (p_qt) else $error("quiet short");
  property p_an;
    tdr_active_o && $past(tdr_active_o) |-> !an_enable_o;
  endproperty
  a_an: assert property (p_an) else $error("aneg in test");
  property p_p100;
    line_i.speed == SP_100 && $past(line_i.speed) == SP_100
      |-> pol_invert_o == 4'h0;
  endproperty
  a_p100: assert property (p_p100) else $error("pol at 100");
  property p_p1g;
    s_glock |-> $stable(pol_invert_o);
  endproperty
  a_p1g: assert property (p_p1g) else $error("pol unlocked");
  property p_p10;
    s_tlink |-> $stable(pol_invert_o);
  endproperty
  a_p10: assert property (p_p10) else $error("pol unlocked");
endmodule
bind ccp_cable_diag ccp_cable_diag_checker #(.QUIET_N(QUIET_N)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .line_i(line_i), .tdr_active_o(tdr_active_o),
  .tdr_pulse_o(tdr_pulse_o), .tdr_pair_o(tdr_pair_o),
  .pol_invert_o(pol_invert_o), .an_enable_o(an_enable_o));
`default_nettype wire

// ===== sim/ccp_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccp_line_model
  import ccp_pkg::*;
(
  // clock and pulse request
  input  wire logic              clk_i,
  input  wire logic              tdr_pulse_i,
  input  wire logic [1:0]        tdr_pair_i,
  // reflections per pair and echo delay
  input  wire ccp_pkg::ccp_tdr_t tab_i [4],
  input  wire logic [7:0]        lat_i,
  // echo
  output logic                   tdr_done_o,
  output ccp_pkg::ccp_tdr_t      tdr_o
);
  logic [7:0] wait_r = 8'h00;
  logic [1:0] pair_r = 2'h0;
  initial tdr_done_o = 1'b0;
  initial tdr_o = '0;
  // echo per pair
  // data toggles outside done so stale values never match
  always @(posedge clk_i)
  begin
    tdr_done_o <= 1'b0;
    tdr_o <= ~tdr_o;
    if (tdr_pulse_i)
    begin
      wait_r <= lat_i;
      pair_r <= tdr_pair_i;
    end
    else if (wait_r != 8'h00)
    begin
      wait_r <= wait_r - 8'h01;
      if (wait_r == 8'h01)
      begin
        tdr_done_o <= 1'b1;
        tdr_o <= tab_i[pair_r];
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/ccp_cable_diag_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ccp_cable_diag_bench;
  import ccp_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0000_0000;
  logic        strap = 1'b0;
  logic [7:0]  lat = 8'h14;
  ccp_line_t   line = '0;
  ccp_tdr_t    tab [4];
  ccp_tdr_t    tdr;
  logic        done, ack, act, pls, mdix, an;
  logic [1:0]  pair;
  logic [3:0]  pol;
  logic [31:0] rdat, q;
  int          miscompares = 0;
  int          n_checks = 0;
  ccp_cable_diag #(.QUIET_N(200), .FAIL_N(50), .SLOT_N(40)) u_ccp_cable_diag (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .auto_crossover_strap_i(strap),
    .line_i(line), .tdr_done_i(done), .tdr_i(tdr), .tdr_active_o(act),
    .tdr_pulse_o(pls), .tdr_pair_o(pair), .mdix_o(mdix),
    .pol_invert_o(pol), .an_enable_o(an));
  ccp_line_model u_ccp_line_model (.clk_i(clk_i), .tdr_pulse_i(pls),
    .tdr_pair_i(pair), .tab_i(tab), .lat_i(lat), .tdr_done_o(done),
    .tdr_o(tdr));
  initial forever #5 clk_i = ~clk_i;
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic hang;
    miscompares++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask
  // classic single cycle; waits for ack, then releases one cycle
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 50)
      hang();
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic t_reset(input logic s);
    rst_i <= 1'b1;
    strap <= s;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(8'h40, s ? 32'h0000_0060 : 32'h0000_0000);
    chk({31'h0, mdix}, 32'h0);
    rdchk(8'h04, 32'h0000_0000);
    $display("reset done");
  endtask
  task automatic lpulse(input logic inv);
    line.pulse_inv <= inv;
    line.link_pulse <= 1'b1;
    @(posedge clk_i);
    line.link_pulse <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_xover;
    line.speed <= SP_10;
    bus(1'b1, 8'h40, 32'h0000_0020);
    chk({31'h0, mdix}, 32'h1);
    lpulse(1'b1);
    rdchk(8'h44, 32'h0000_0042);
    line.link_up <= 1'b1;
    lpulse(1'b0);
    chk({28'h0, pol}, 32'h1);
    bus(1'b1, 8'h40, 32'h0000_0000);
    rdchk(8'h44, 32'h0000_0000);
    sel <= 4'he;
    bus(1'b1, 8'h40, 32'h0000_0060);
    sel <= 4'hf;
    rdchk(8'h40, 32'h0000_0000);
    line.speed <= SP_100;
    repeat (3) @(posedge clk_i);
    chk({28'h0, pol}, 32'h0);
    $display("xover done");
  endtask
  task automatic t_gig;
    line <= '{speed: SP_1000, link_up: 1'b1, idle_inv: 4'ha, cd_swap: 1'b1,
              len: 3'h5, skew: 16'h1234, default: '0};
    repeat (3) @(posedge clk_i);
    line.descr_lock <= 1'b1;
    line.idle_inv <= 4'h5;
    rdchk(8'h44, 32'h0000_0282);
    bus(1'b1, 8'h58, 32'h0000_0005);
    rdchk(8'h70, 32'h0000_006a);
    bus(1'b1, 8'h58, 32'h0000_0004);
    rdchk(8'h70, 32'h0000_1234);
    bus(1'b1, 8'h58, 32'h0000_0006);
    rdchk(8'h70, 32'h0000_0000);
    line.descr_lock <= 1'b0;
    bus(1'b1, 8'h58, 32'h0000_0005);
    rdchk(8'h70, 32'h0000_0025);
    $display("gigabit done");
  endtask
  // launch, poll start bit, read each pair through selector
  task automatic run(input logic [31:0] e0, input logic f);
    int n;
    logic [1:0] v;
    n = 0;
    bus(1'b1, 8'h70, 32'h0000_8000);
    do
    begin
      bus(1'b0, 8'h70, 32'h0000_0000);
      n++;
    end
    while (q[15] && n < 200);
    if (n >= 200)
      hang();
    for (int p = 0; p < 4; p++)
    begin
      v = tab[p].hit ? (tab[p].neg ? 2'b01 : 2'b10) : 2'b00;
      bus(1'b1, 8'h58, 32'(p));
      rdchk(8'h70, f ? e0 : {17'h0, v, tab[p].amp, tab[p].dly});
    end
  endtask
  task automatic t_test;
    line <= '{speed: SP_NONE, default: '0};
    tab[0] = '0;
    tab[1] = '{hit: 1'b1, neg: 1'b1, amp: 5'h1f, dly: 8'h10};
    tab[2] = '{hit: 1'b1, neg: 1'b0, amp: 5'h0a, dly: 8'hc8};
    tab[3] = '{hit: 1'b1, neg: 1'b1, amp: 5'h01, dly: 8'h01};
    run(32'h0000_0000, 1'b0);
    lat <= 8'h01;
    run(32'h0000_0000, 1'b0);
    line.sig_det <= 1'b1;
    run(32'h0000_6000, 1'b1);
    line.sig_det <= 1'b0;
    $display("cable test done");
  endtask
  task automatic t_auto;
    int n;
    logic m;
    n = 0;
    while (mdix !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000)
      hang();
    chk({31'h0, mdix}, 32'h1);
    line.sig_det <= 1'b1;
    repeat (80) @(posedge clk_i);
    m = mdix;
    repeat (120) @(posedge clk_i);
    chk({30'h0, an, mdix}, {30'h0, 1'b1, m});
    $display("auto crossover done");
  endtask
  initial
  begin
    line.speed <= SP_NONE;
    for (int p = 0; p < 4; p++)
      tab[p] = '0;
    t_reset(1'b0);
    t_xover();
    t_gig();
    t_test();
    t_reset(1'b1);
    t_auto();
    complete_run();
  end
endmodule
`default_nettype wire
